//--- pkg/gpp_defines.svh
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

// Port geometry
`define GPP_PORT_W         8
`define GPP_TX_CH          2
`define GPP_TX0_PIN        0
`define GPP_TX1_PIN        3

// Bus geometry
`define GPP_ADR_W          4
`define GPP_DAT_W          32
`define GPP_SEL_W          4

// Register byte offsets
`define GPP_OFS_DIRECTION  4'h0
`define GPP_OFS_LATCH      4'h4
`define GPP_OFS_READBACK   4'h8
`define GPP_OFS_PULLUP     4'hc

// Reset values
`define GPP_RST_DIRECTION  8'h00
`define GPP_RST_LATCH      8'h00
`define GPP_RST_PULLUP     8'h00

// Value returned by a direction register read
`define GPP_DIR_READ_FILL  8'hff
`define GPP_DAT_ZERO       32'h0000_0000
`define GPP_UPPER_ZERO     24'h00_0000

`endif

//--- pkg/gpp_pkg.sv
`include "gpp_defines.svh"

package gpp_pkg;

  typedef enum logic [0:0]
  {
    GPP_BUS_IDLE = 1'b0,
    GPP_BUS_ACK  = 1'b1
  } gpp_bus_e;

  typedef struct packed
  {
    gpp_bus_e                   bus;
    logic [`GPP_DAT_W-1:0]      rdata;
    logic [`GPP_PORT_W-1:0]     direction;
    logic [`GPP_PORT_W-1:0]     latch;
    logic [`GPP_PORT_W-1:0]     pull_ctl;
  } gpp_core_s;

  typedef struct packed
  {
    logic [`GPP_PORT_W-1:0]     pin_out;
    logic [`GPP_PORT_W-1:0]     pin_oe;
    logic [`GPP_PORT_W-1:0]     pullup_en;
  } gpp_pin_s;

endpackage

//--- rtl/gpp_pin_stage.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpp_defines.svh"

module gpp_pin_stage
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  // Configuration from the register file
  input  wire logic [`GPP_PORT_W-1:0]    direction,
  input  wire logic [`GPP_PORT_W-1:0]    latch,
  input  wire logic [`GPP_PORT_W-1:0]    pull_ctl,
  // Serial transmitters sharing pins
  input  wire logic [`GPP_TX_CH-1:0]     serial_transmit_enable,
  input  wire logic [`GPP_TX_CH-1:0]     serial_tx_data,
  // Registered pin controls
  output logic      [`GPP_PORT_W-1:0]    pin_out,
  output logic      [`GPP_PORT_W-1:0]    pin_oe,
  output logic      [`GPP_PORT_W-1:0]    pullup_en
);

  gpp_pkg::gpp_pin_s                     state;
  gpp_pkg::gpp_pin_s                     next_state;
  logic [`GPP_PORT_W-1:0]                tx_own;
  logic [`GPP_PORT_W-1:0]                tx_lvl;

  //////////////////////////////////////////////////////////////////////////
  // Map transmitter channels onto their pins
  genvar i;
  generate
    for (i = 0; i < `GPP_PORT_W; i = i + 1)
    begin : g_pin
      if (i == `GPP_TX0_PIN)
      begin : g_tx0
        assign tx_own[i] = serial_transmit_enable[0];
        assign tx_lvl[i] = serial_tx_data[0];
      end
      else if (i == `GPP_TX1_PIN)
      begin : g_tx1
        assign tx_own[i] = serial_transmit_enable[1];
        assign tx_lvl[i] = serial_tx_data[1];
      end
      else
      begin : g_gp
        assign tx_own[i] = 1'b0;
        assign tx_lvl[i] = 1'b0;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state           = state;
    next_state.pin_oe    = direction | tx_own;
    next_state.pin_out   = (tx_own & tx_lvl) | (~tx_own & latch);
    // Judged on the effective drive so a transmitter also kills the pull-up
    next_state.pullup_en = pull_ctl & ~(direction | tx_own);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state <= '0;
    else
      state <= next_state;
  end

  assign pin_out   = state.pin_out;
  assign pin_oe    = state.pin_oe;
  assign pullup_en = state.pullup_en;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_pullup_off_drive: assert property ((pin_oe & pullup_en) == '0)
    else $error("pull-up active on a driven pin");
  a_tx_takes_pin: assert property (serial_transmit_enable[0] |=>
    pin_oe[`GPP_TX0_PIN] && pin_out[`GPP_TX0_PIN] == $past(serial_tx_data[0]))
    else $error("transmitter did not take its pin");

endmodule
`default_nettype wire

//--- rtl/gpp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpp_defines.svh"

module gpp_port
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  // Wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [`GPP_ADR_W-1:0]     wb_adr_i,
  input  wire logic [`GPP_SEL_W-1:0]     wb_sel_i,
  input  wire logic [`GPP_DAT_W-1:0]     wb_dat_i,
  output logic      [`GPP_DAT_W-1:0]     wb_dat_o,
  output logic                           wb_ack_o,
  // Serial transmitters sharing pins
  input  wire logic [`GPP_TX_CH-1:0]     serial_transmit_enable,
  input  wire logic [`GPP_TX_CH-1:0]     serial_tx_data,
  // Port pins
  input  wire logic [`GPP_PORT_W-1:0]    pin_in,
  output logic      [`GPP_PORT_W-1:0]    pin_out,
  output logic      [`GPP_PORT_W-1:0]    pin_oe,
  output logic      [`GPP_PORT_W-1:0]    pullup_en
);

  gpp_pkg::gpp_core_s                    state;
  gpp_pkg::gpp_core_s                    next_state;
  logic                                  take;
  logic                                  wr_lane;
  logic                                  hit_dir;
  logic                                  hit_latch;
  logic                                  hit_rb;
  logic                                  hit_pu;
  logic [`GPP_PORT_W-1:0]                readback;
  logic [`GPP_PORT_W-1:0]                wbyte;

  //////////////////////////////////////////////////////////////////////////
  // Request acceptance and address decode

  // One access per request; take is blocked during the ack cycle, so a
  // strobe dropped on the edge that samples ack is taken only once.
  assign take    = wb_cyc_i && wb_stb_i && (state.bus == gpp_pkg::GPP_BUS_IDLE);
  assign wr_lane = take && wb_we_i && wb_sel_i[0];
  assign wbyte   = wb_dat_i[`GPP_PORT_W-1:0];

  always_comb
  begin
    hit_dir   = 1'b0;
    hit_latch = 1'b0;
    hit_rb    = 1'b0;
    hit_pu    = 1'b0;
    if (wb_adr_i == `GPP_OFS_DIRECTION)
      hit_dir = 1'b1;
    else if (wb_adr_i == `GPP_OFS_LATCH)
      hit_latch = 1'b1;
    else if (wb_adr_i == `GPP_OFS_READBACK)
      hit_rb = 1'b1;
    else if (wb_adr_i == `GPP_OFS_PULLUP)
      hit_pu = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin readback mixes latch and live pins per direction bit

  // Pins are taken as synchronous, so no synchroniser sits here
  assign readback = (state.direction & state.latch)
                  | (~state.direction & pin_in);

  //////////////////////////////////////////////////////////////////////////
  // Register file and bus answer

  always_comb
  begin
    next_state = state;
    case (state.bus)
      gpp_pkg::GPP_BUS_IDLE:
      begin
        if (take)
        begin
          next_state.bus = gpp_pkg::GPP_BUS_ACK;
          next_state.rdata = `GPP_DAT_ZERO;
          if (!wb_we_i)
          begin
            // Software must shadow the direction; hardware hides it
            if (hit_dir)
              next_state.rdata = {`GPP_UPPER_ZERO, `GPP_DIR_READ_FILL};
            else if (hit_latch)
              next_state.rdata = {`GPP_UPPER_ZERO, state.latch};
            else if (hit_rb)
              next_state.rdata = {`GPP_UPPER_ZERO, readback};
            else if (hit_pu)
              next_state.rdata = {`GPP_UPPER_ZERO, state.pull_ctl};
          end
        end
        if (wr_lane)
        begin
          if (hit_dir)
            next_state.direction = wbyte;
          else if (hit_latch)
            next_state.latch = wbyte;
          else if (hit_pu)
            next_state.pull_ctl = wbyte;
          // Readback and unmapped writes are acknowledged and dropped
        end
      end
      gpp_pkg::GPP_BUS_ACK:
      begin
        next_state.bus   = gpp_pkg::GPP_BUS_IDLE;
        next_state.rdata = `GPP_DAT_ZERO;
      end
      default:
      begin
        next_state.bus = gpp_pkg::GPP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state.bus       <= gpp_pkg::GPP_BUS_IDLE;
      state.rdata     <= `GPP_DAT_ZERO;
      state.direction <= `GPP_RST_DIRECTION;
      state.latch     <= `GPP_RST_LATCH;
      state.pull_ctl  <= `GPP_RST_PULLUP;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign wb_ack_o = (state.bus == gpp_pkg::GPP_BUS_ACK);
  assign wb_dat_o = state.rdata;

  //////////////////////////////////////////////////////////////////////////
  // Pin drive stage

  gpp_pin_stage u_pin_stage
  (
    .sys_clk                (sys_clk),
    .rstn                   (rstn),
    .direction              (state.direction),
    .latch                  (state.latch),
    .pull_ctl               (state.pull_ctl),
    .serial_transmit_enable (serial_transmit_enable),
    .serial_tx_data         (serial_tx_data),
    .pin_out                (pin_out),
    .pin_oe                 (pin_oe),
    .pullup_en              (pullup_en)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic                                  rd_take;
  logic                                  wr_take;
  logic                                  any_hit;
  logic                                  tx_idle;
  assign rd_take = take && !wb_we_i;
  assign wr_take = take && wb_we_i;
  assign any_hit = hit_dir || hit_latch || hit_rb || hit_pu;
  assign tx_idle = (serial_transmit_enable == '0);

  a_ack_follows_req: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not given for exactly one cycle");

  a_ack_has_cause: assert property (wb_ack_o |-> $past(take))
    else $error("ack without an accepted request");

  a_dir_write: assert property (wr_lane && hit_dir |=>
    state.direction == $past(wbyte))
    else $error("direction write lost");

  a_dir_read_fill: assert property (rd_take && hit_dir |=>
    wb_dat_o == {`GPP_UPPER_ZERO, `GPP_DIR_READ_FILL})
    else $error("direction read did not return the filler");

  // Write then read at the master's spacing of three edges between takes
  a_latch_roundtrip: assert property (wr_lane && hit_latch ##3
    rd_take && hit_latch |=> wb_dat_o[`GPP_PORT_W-1:0] == $past(wbyte, 4))
    else $error("latch read back differs from write");

  a_rb_ignores_write: assert property (wr_take && hit_rb |=>
    $stable(state.direction) && $stable(state.latch) && $stable(state.pull_ctl))
    else $error("readback write changed state");

  a_rb_mix: assert property (rd_take && hit_rb |=>
    wb_dat_o[`GPP_PORT_W-1:0] ==
    (($past(state.direction) & $past(state.latch)) |
     (~$past(state.direction) & $past(pin_in))))
    else $error("readback mix wrong");

  a_pullup_write: assert property (wr_lane && hit_pu |=>
    state.pull_ctl == $past(wbyte))
    else $error("pull-up control write lost");

  a_pin_drive: assert property (serial_transmit_enable == '0 |=>
    pin_oe == $past(state.direction) && pin_out == $past(state.latch))
    else $error("pin drive does not follow direction and latch");

  a_pullup_input: assert property (serial_transmit_enable == '0 |=>
    pullup_en == ($past(state.pull_ctl) & ~$past(state.direction)))
    else $error("pull-up enable wrong");

  a_tx1_takes_pin: assert property (serial_transmit_enable[1] |=>
    pin_oe[`GPP_TX1_PIN] && pin_out[`GPP_TX1_PIN] == $past(serial_tx_data[1]))
    else $error("second transmitter did not take its pin");

  a_upper_zero: assert property (wb_dat_o[`GPP_DAT_W-1:`GPP_PORT_W] == '0)
    else $error("upper read data not zero");

  a_no_retake: assert property (wb_ack_o |-> !take)
    else $error("request taken while ack is high");

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == `GPP_DAT_ZERO)
    else $error("read data not cleared outside ack");

  a_wr_ack_zero: assert property (wr_take |=> wb_dat_o == `GPP_DAT_ZERO)
    else $error("write ack carried read data");

  a_unmapped_read: assert property (rd_take && !any_hit |=> wb_dat_o == `GPP_DAT_ZERO)
    else $error("unmapped read not zero");

  a_rb_write_ack: assert property (wr_take && hit_rb |=> wb_ack_o)
    else $error("readback write not acknowledged");

  a_lane_gate: assert property (take && wb_we_i && !wb_sel_i[0] |=>
    $stable(state.direction) && $stable(state.latch) && $stable(state.pull_ctl))
    else $error("write with lane 0 off changed state");

  a_dir_hold: assert property (!(wr_lane && hit_dir) |=>
    $stable(state.direction))
    else $error("direction changed without a write");

  a_latch_hold: assert property (!(wr_lane && hit_latch) |=>
    $stable(state.latch))
    else $error("output latch changed without a write");

  a_pullup_hold: assert property (!(wr_lane && hit_pu) |=>
    $stable(state.pull_ctl))
    else $error("pull-up control changed without a write");

  a_latch_write: assert property (wr_lane && hit_latch |=>
    state.latch == $past(wbyte))
    else $error("output latch write lost");

  a_latch_read: assert property (rd_take && hit_latch |=>
    wb_dat_o[`GPP_PORT_W-1:0] == $past(state.latch))
    else $error("output latch read wrong");

  a_pullup_read: assert property (rd_take && hit_pu |=>
    wb_dat_o[`GPP_PORT_W-1:0] == $past(state.pull_ctl))
    else $error("pull-up control read wrong");

  a_tx0_no_pullup: assert property (serial_transmit_enable[0] |=>
    !pullup_en[`GPP_TX0_PIN])
    else $error("pull-up left on under the first transmitter");

  a_tx1_no_pullup: assert property (serial_transmit_enable[1] |=>
    !pullup_en[`GPP_TX1_PIN])
    else $error("pull-up left on under the second transmitter");

  // Checked one edge on: a reset taken at time zero may not yet have settled
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=>
    !wb_ack_o && wb_dat_o == `GPP_DAT_ZERO && pin_oe == '0 && pullup_en == '0)
    else $error("outputs not quiet after reset");

  //////////////////////////////////////////////////////////////////////////
  // Per-pin checks

  genvar p;
  generate
    for (p = 0; p < `GPP_PORT_W; p = p + 1)
    begin : g_pin_chk
      a_rb_out_bit: assert property (rd_take && hit_rb && state.direction[p] |=>
        wb_dat_o[p] == $past(state.latch[p]))
        else $error("readback of an output pin is not the latch");

      a_rb_in_bit: assert property (rd_take && hit_rb && !state.direction[p] |=>
        wb_dat_o[p] == $past(pin_in[p]))
        else $error("readback of an input pin is not the pin level");

      a_oe_bit: assert property (state.direction[p] |=> pin_oe[p])
        else $error("output pin not driven");

      a_in_bit: assert property (tx_idle && !state.direction[p] |=> !pin_oe[p])
        else $error("input pin driven");

      a_pu_bit: assert property (tx_idle && !state.direction[p] |=>
        pullup_en[p] == $past(state.pull_ctl[p]))
        else $error("input pin pull-up does not follow its control bit");

      a_pu_out_bit: assert property (state.direction[p] |=> !pullup_en[p])
        else $error("pull-up on while the pin drives");
    end
  endgenerate

  c_dir_write: cover property (wr_lane && hit_dir);
  c_rb_read_mixed: cover property (rd_take && hit_rb &&
    state.direction != '0 && state.direction != '1);
  c_tx_override: cover property (serial_transmit_enable[0] && !state.direction[`GPP_TX0_PIN]);
  c_back_to_back: cover property (take ##2 take);
  c_pullup_on: cover property (tx_idle && pullup_en != '0);

endmodule
`default_nettype wire

//--- dv/gpp_board.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpp_defines.svh"

module gpp_board
(
  // Clock
  input  wire logic                   sys_clk,
  // Pin controls from the port
  input  wire logic [`GPP_PORT_W-1:0] pin_out,
  input  wire logic [`GPP_PORT_W-1:0] pin_oe,
  input  wire logic [`GPP_PORT_W-1:0] pullup_en,
  // External drivers on the board
  input  wire logic [`GPP_PORT_W-1:0] ext_val,
  input  wire logic [`GPP_PORT_W-1:0] ext_en,
  // Resolved pin levels
  output logic      [`GPP_PORT_W-1:0] pin_in
);
  logic [`GPP_PORT_W-1:0] wobble;

  // Undriven pins toggle so a floating read never looks stable
  initial wobble = 8'h55;
  always @(posedge sys_clk) wobble <= ~wobble;

  always_comb
  begin
    for (int i = 0; i < `GPP_PORT_W; i++)
    begin
      // A board driver overpowers the port, so a driven pin may differ from its latch
      if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = wobble[i];
    end
  end
endmodule
`default_nettype wire

//--- dv/gpp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpp_defines.svh"

module gpp_port_tb;
  logic        sys_clk, rstn, cyc, stb, we;
  logic [3:0]  adr, sel;
  logic [31:0] dat_i, dat_o, rd;
  logic        ack;
  logic [1:0]  tx_en, tx_dat;
  logic [7:0]  pin_in, pin_out, pin_oe, pullup_en, ext_val, ext_en;
  int          errors, n_compared, cycles;

  gpp_port u_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .serial_transmit_enable(tx_en), .serial_tx_data(tx_dat),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en));

  gpp_board u_board (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard; the whole run needs about a hundred and ten cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles > 3000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_i <= {24'h00_0000, d};
    // Ends when ack is sampled high; an ack that never comes is caught by the bench timeout
    do
    begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00, 4'hf);
    chk(rd, {24'h00_0000, exp});
  endtask

  // Pins follow a write one edge after the ack
  task automatic settle;
    repeat (2) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({24'h0, pin_oe}, 32'h0);
    chk({24'h0, pullup_en}, 32'h0);
    rdchk(`GPP_OFS_DIRECTION, `GPP_DIR_READ_FILL);
    rdchk(`GPP_OFS_LATCH, `GPP_RST_LATCH);
    rdchk(`GPP_OFS_PULLUP, `GPP_RST_PULLUP);
  endtask

  task automatic t_drive;
    wr(`GPP_OFS_DIRECTION, 8'hf0);
    wr(`GPP_OFS_LATCH, 8'h96);
    rdchk(`GPP_OFS_LATCH, 8'h96);
    settle();
    chk({24'h0, pin_oe}, 32'hf0);
    chk({24'h0, pin_out & pin_oe}, 32'h90);
    rdchk(`GPP_OFS_LATCH, 8'h96);
    rdchk(`GPP_OFS_DIRECTION, `GPP_DIR_READ_FILL);
  endtask

  task automatic t_readback;
    ext_val <= 8'h3c;
    ext_en <= 8'hf1;
    wr(`GPP_OFS_DIRECTION, 8'h0f);
    wr(`GPP_OFS_LATCH, 8'ha5);
    settle();
    rdchk(`GPP_OFS_READBACK, 8'h35);
    wr(`GPP_OFS_READBACK, 8'h00);
    rdchk(`GPP_OFS_LATCH, 8'ha5);
    rdchk(`GPP_OFS_READBACK, 8'h35);
  endtask

  task automatic t_pullup;
    ext_en <= 8'h00;
    wr(`GPP_OFS_PULLUP, 8'hff);
    settle();
    rdchk(`GPP_OFS_PULLUP, 8'hff);
    chk({24'h0, pullup_en}, 32'hf0);
    rdchk(`GPP_OFS_READBACK, 8'hf5);
    wr(`GPP_OFS_DIRECTION, 8'h00);
    wr(`GPP_OFS_PULLUP, 8'h30);
    settle();
    chk({24'h0, pullup_en}, 32'h30);
  endtask

  task automatic t_tx;
    wr(`GPP_OFS_PULLUP, 8'hff);
    tx_dat <= 2'b10;
    tx_en <= 2'b11;
    settle();
    chk({24'h0, pin_oe}, 32'h09);
    chk({24'h0, pin_out & 8'h09}, 32'h08);
    chk({24'h0, pullup_en}, 32'hf6);
    tx_en <= 2'b00;
    settle();
    chk({24'h0, pin_oe}, 32'h00);
  endtask

  task automatic t_odd;
    wb(1'b1, `GPP_OFS_LATCH, 8'h11, 4'he);
    rdchk(`GPP_OFS_LATCH, 8'ha5);
    wr(4'h6, 8'h00);
    rdchk(4'h6, 8'h00);
    rdchk(`GPP_OFS_PULLUP, 8'hff);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0;
    n_compared = 0;
    cycles = 0;
    rstn = 1'b0;
    {cyc, stb, we} = 3'b000;
    adr = 4'h0;
    sel = 4'h0;
    dat_i = 32'h0;
    tx_en = 2'b00;
    tx_dat = 2'b00;
    ext_val = 8'h00;
    ext_en = 8'h00;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_drive();
    t_readback();
    t_pullup();
    t_tx();
    t_odd();
    repeat (2) @(posedge sys_clk);
    test_done();
  end
endmodule
`default_nettype wire
